// >>> include/pss_regs.vh
`ifndef PSS_REGS_VH
`define PSS_REGS_VH

// ----------------------------------------------------------------
// Clock and settling times
// ----------------------------------------------------------------
`define PSS_CLK_MHZ          100
`define PSS_XO_SETTLE_US     1000
`define PSS_PLL_SETTLE_US    50
`define PSS_XO_SETTLE_CYC    (`PSS_XO_SETTLE_US * `PSS_CLK_MHZ)
`define PSS_PLL_SETTLE_CYC   (`PSS_PLL_SETTLE_US * `PSS_CLK_MHZ)
`define PSS_SETTLE_CW        17

// ----------------------------------------------------------------
// Crystal trim, in ppm steps, two's complement
// ----------------------------------------------------------------
`define PSS_TRIM_W           8
`define PSS_TRIM_MAX         8'h14
`define PSS_TRIM_MIN         8'hEC
`define PSS_TRIM_RST         8'h00

// ----------------------------------------------------------------
// Wake timer and sleep clock calibration widths and resets
// ----------------------------------------------------------------
`define PSS_WAKE_W           16
`define PSS_WAKE_RST         16'h0000
`define PSS_CAL_W            16
`define PSS_CAL_RST          16'h0000

`endif

// >>> hdl/pss_step_timer.v
`timescale 1ns/1ps
module pss_step_timer #(
	parameter CW    = 17,
	parameter COUNT = 100000
) (
	input  wire sys_clk,
	input  wire sys_rst,
	input  wire start,
	output reg  done_r
);
	localparam integer  LOAD_I = COUNT - 1;
	localparam [CW-1:0] LOAD   = LOAD_I[CW-1:0];

	reg [CW-1:0] cnt_r;
	reg          busy_r;

	// ----------------------------------------------------------------
	// Down counter, done holds until the next start
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt_r  <= {CW{1'b0}};
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else if (start) begin
			cnt_r  <= LOAD;
			busy_r <= 1'b1;
			done_r <= 1'b0;
		end else if (busy_r) begin
			if (cnt_r == {CW{1'b0}}) begin
				busy_r <= 1'b0;
				done_r <= 1'b1;
			end else begin
				cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule

// >>> hdl/pss_sequencer.v
// What this block does
// R01: Shutdown keeps nothing; regulator, logic, RAMs, analog and host port unpowered.
// R02: In Shutdown every input is ignored except the supply enable.
// R03: Sleep keeps retention RAM and host port powered, logic and scratch RAM off.
// R04: Sleep runs on the RC clock, crystal stopped, regulator in low-power mode.
// R05: Sleep ends on a host access or on wake timer expiry.
// R06: Regulator low-power in Sleep, high-power in Active.
// R07: Active is exactly one of Transmit, Receive or Idle; only needed chains on.
// R08: Idle is the brief fallback when no receive is needed, e.g. after abort.
// R09: Sleep and Active moves happen without any host control action.
// R10: Supply enable low sends the device to Shutdown from any state.
// R11: Supply enable high powers up into Active, Idle sub-state.
// R12: After power-up the host boots the device; boot completion allows Sleep.
// R13: Unassociated, Sleep is entered whenever no host activity is pending.
// R14: Associated, Sleep follows the negotiated powersave windows.
// R15: Any host transaction wakes from Sleep; none is needed to enter Sleep.
// R16: Wake order: regulator, power, crystal, PLL, cores, baseband, radio.
// R17: Early wake steps take equal time from Shutdown and from Sleep.
// R18: From Shutdown full baseband init and factory block copy; Sleep reuses state.
// R19: From Shutdown full radio calibration; from Sleep current channel only.
// R20: Crystal trim from stored value, limited to 20 ppm either way.
// R21: Sleep clock is calibrated against the crystal reference at run time.
// R22: Wake interval counts from the latest beacon so error never accumulates.
// R23: Crystal and PLL steps advance on settled indication or settle counter.
`timescale 1ns/1ps
`include "pss_regs.vh"
module pss_sequencer #(
	parameter XO_SETTLE_CYC  = `PSS_XO_SETTLE_CYC,
	parameter PLL_SETTLE_CYC = `PSS_PLL_SETTLE_CYC
) (
	input  wire                    sys_clk,
	input  wire                    sys_rst,
	input  wire                    supply_enable_input,
	input  wire                    host_access,
	input  wire                    boot_done,
	input  wire                    host_activity_pending,
	input  wire                    associated,
	input  wire                    ps_sleep_allowed,
	input  wire                    tx_req,
	input  wire                    rx_req,
	input  wire                    rx_abort,
	input  wire                    xo_settled,
	input  wire                    pll_settled,
	input  wire                    cores_booted,
	input  wire                    bb_init_done,
	input  wire                    rf_cal_done,
	input  wire                    rc_tick,
	input  wire                    dtim_beacon,
	input  wire [`PSS_WAKE_W-1:0]  wake_interval,
	input  wire [`PSS_TRIM_W-1:0]  otp_trim,
	input  wire                    otp_trim_valid,
	output reg                     regulator_pwm_r,
	output reg                     pulse_frequency_regulation_r,
	output reg                     logic_pwr_r,
	output reg                     scratch_ram_pwr_r,
	output reg                     analog_pwr_r,
	output reg                     retention_ram_pwr_r,
	output reg                     host_if_pwr_r,
	output reg                     rc_osc_en_r,
	output reg                     xo_en_r,
	output reg                     pll_en_r,
	output reg                     core_run_r,
	output reg                     bb_init_req_r,
	output reg                     factory_info_block_copy_r,
	output reg                     rf_cal_req_r,
	output reg                     rf_cal_all_bands_r,
	output reg                     state_shutdown_r,
	output reg                     state_sleep_r,
	output reg                     state_active_r,
	output reg                     tx_chain_en_r,
	output reg                     rx_chain_en_r,
	output reg                     active_idle_r,
	output reg                     booted_r,
	output reg [`PSS_TRIM_W-1:0]   xo_trim_r,
	output reg [`PSS_CAL_W-1:0]    rc_period_r,
	output reg                     rc_cal_valid_r
);
	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam [9:0] ST_SHUT   = 10'h001;
	localparam [9:0] ST_PMU    = 10'h002;
	localparam [9:0] ST_PWR    = 10'h004;
	localparam [9:0] ST_XO     = 10'h008;
	localparam [9:0] ST_PLL    = 10'h010;
	localparam [9:0] ST_BOOT   = 10'h020;
	localparam [9:0] ST_BBINIT = 10'h040;
	localparam [9:0] ST_RFCAL  = 10'h080;
	localparam [9:0] ST_ACT    = 10'h100;
	localparam [9:0] ST_SLEEP  = 10'h200;

	localparam [2:0] SUB_NONE  = 3'h0;
	localparam [2:0] SUB_IDLE  = 3'h1;
	localparam [2:0] SUB_TX    = 3'h2;
	localparam [2:0] SUB_RX    = 3'h4;

	reg [9:0]              state_r;
	reg [9:0]              state_nxt;
	reg [2:0]              sub_r;
	reg [2:0]              sub_nxt;
	reg                    from_shut_r;
	reg [`PSS_WAKE_W-1:0]  wake_cnt_r;
	reg [`PSS_CAL_W-1:0]   cal_cnt_r;

	wire                   xo_timer_done;
	wire                   pll_timer_done;
	wire                   xo_start;
	wire                   pll_start;
	wire                   wake_expired;
	wire                   sleep_ok;
	wire                   ps_window;
	wire                   trim_hi;
	wire                   trim_lo;

	// ----------------------------------------------------------------
	// Settling counters
	// ----------------------------------------------------------------
	assign xo_start  = (state_nxt == ST_XO) && (state_r != ST_XO);
	assign pll_start = (state_nxt == ST_PLL) && (state_r != ST_PLL);

	pss_step_timer #(
		.CW    (`PSS_SETTLE_CW),
		.COUNT (XO_SETTLE_CYC)
	) u_xo_timer (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.start   (xo_start),
		.done_r  (xo_timer_done)
	);

	pss_step_timer #(
		.CW    (`PSS_SETTLE_CW),
		.COUNT (PLL_SETTLE_CYC)
	) u_pll_timer (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.start   (pll_start),
		.done_r  (pll_timer_done)
	);

	// ----------------------------------------------------------------
	// Sleep decision and wake sources
	// ----------------------------------------------------------------
	assign wake_expired = (state_r == ST_SLEEP) && (wake_interval != `PSS_WAKE_RST)
		&& (wake_cnt_r >= wake_interval); // R05 R22
	assign ps_window = associated ? ps_sleep_allowed : ~host_activity_pending; // R13 R14
	assign sleep_ok  = booted_r && (sub_r == SUB_IDLE) && ps_window
		&& ~host_access && ~tx_req && ~rx_req; // R09 R12 R15

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_SHUT: begin
				if (supply_enable_input)
					state_nxt = ST_PMU; // R02 R11
			end
			ST_PMU: begin
				state_nxt = ST_PWR; // R16 R17
			end
			ST_PWR: begin
				state_nxt = ST_XO; // R16 R17
			end
			ST_XO: begin
				if (xo_settled || xo_timer_done)
					state_nxt = ST_PLL; // R23
			end
			ST_PLL: begin
				if (pll_settled || pll_timer_done)
					state_nxt = ST_BOOT; // R23
			end
			ST_BOOT: begin
				if (cores_booted)
					state_nxt = ST_BBINIT; // R16
			end
			ST_BBINIT: begin
				if (bb_init_done)
					state_nxt = ST_RFCAL; // R16
			end
			ST_RFCAL: begin
				if (rf_cal_done)
					state_nxt = ST_ACT; // R16
			end
			ST_ACT: begin
				if (sleep_ok)
					state_nxt = ST_SLEEP; // R09 R13 R14
			end
			ST_SLEEP: begin
				if (host_access || wake_expired)
					state_nxt = ST_PMU; // R05 R15
			end
			default: begin
				state_nxt = ST_SHUT;
			end
		endcase
		if (!supply_enable_input)
			state_nxt = ST_SHUT; // R10
	end

	// ----------------------------------------------------------------
	// Active sub-state, exactly one while active
	// ----------------------------------------------------------------
	always @* begin
		sub_nxt = SUB_NONE;
		if (state_nxt == ST_ACT) begin
			if (tx_req)
				sub_nxt = SUB_TX; // R07
			else if (rx_req && !rx_abort)
				sub_nxt = SUB_RX; // R07
			else
				sub_nxt = SUB_IDLE; // R08 R11
		end
	end

	// ----------------------------------------------------------------
	// State, origin and boot tracking
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			state_r     <= ST_SHUT;
			sub_r       <= SUB_NONE;
			from_shut_r <= 1'b1;
			booted_r    <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sub_r   <= sub_nxt;
			if (state_nxt == ST_SHUT)
				from_shut_r <= 1'b1; // R18 R19
			else if (state_r == ST_SLEEP && state_nxt == ST_PMU)
				from_shut_r <= 1'b0; // R18 R19
			if (state_nxt == ST_SHUT)
				booted_r <= 1'b0; // R01
			else if (state_r == ST_ACT && boot_done)
				booted_r <= 1'b1; // R12
		end
	end

	// ----------------------------------------------------------------
	// Power, clock and step outputs
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			regulator_pwm_r              <= 1'b0;
			pulse_frequency_regulation_r <= 1'b0;
			logic_pwr_r                  <= 1'b0;
			scratch_ram_pwr_r            <= 1'b0;
			analog_pwr_r                 <= 1'b0;
			retention_ram_pwr_r          <= 1'b0;
			host_if_pwr_r                <= 1'b0;
			rc_osc_en_r                  <= 1'b0;
			xo_en_r                      <= 1'b0;
			pll_en_r                     <= 1'b0;
			core_run_r                   <= 1'b0;
			bb_init_req_r                <= 1'b0;
			factory_info_block_copy_r    <= 1'b0;
			rf_cal_req_r                 <= 1'b0;
			rf_cal_all_bands_r           <= 1'b0;
			state_shutdown_r             <= 1'b1;
			state_sleep_r                <= 1'b0;
			state_active_r               <= 1'b0;
			tx_chain_en_r                <= 1'b0;
			rx_chain_en_r                <= 1'b0;
			active_idle_r                <= 1'b0;
		end else begin
			regulator_pwm_r <= (state_nxt & (ST_SHUT | ST_SLEEP)) == 10'h000; // R06 R16
			pulse_frequency_regulation_r <= state_nxt == ST_SLEEP; // R04 R06
			logic_pwr_r <= (state_nxt & (ST_SHUT | ST_SLEEP | ST_PMU)) == 10'h000; // R01 R03
			scratch_ram_pwr_r <= (state_nxt & (ST_SHUT | ST_SLEEP | ST_PMU)) == 10'h000; // R03
			analog_pwr_r <= (state_nxt & (ST_SHUT | ST_SLEEP | ST_PMU)) == 10'h000; // R01 R16
			retention_ram_pwr_r <= state_nxt != ST_SHUT; // R01 R03
			host_if_pwr_r       <= state_nxt != ST_SHUT; // R01 R03
			rc_osc_en_r         <= state_nxt != ST_SHUT; // R04
			xo_en_r  <= (state_nxt & (ST_XO | ST_PLL | ST_BOOT | ST_BBINIT | ST_RFCAL
				| ST_ACT)) != 10'h000; // R04 R16
			pll_en_r <= (state_nxt & (ST_PLL | ST_BOOT | ST_BBINIT | ST_RFCAL
				| ST_ACT)) != 10'h000; // R16
			core_run_r <= (state_nxt & (ST_BOOT | ST_BBINIT | ST_RFCAL | ST_ACT)) != 10'h000;
			bb_init_req_r <= state_nxt == ST_BBINIT; // R16
			factory_info_block_copy_r <= (state_nxt == ST_BBINIT) && from_shut_r; // R18
			rf_cal_req_r <= state_nxt == ST_RFCAL; // R16
			rf_cal_all_bands_r <= (state_nxt == ST_RFCAL) && from_shut_r; // R19
			state_shutdown_r <= state_nxt == ST_SHUT;
			state_sleep_r    <= state_nxt == ST_SLEEP;
			state_active_r   <= state_nxt == ST_ACT;
			tx_chain_en_r    <= sub_nxt == SUB_TX; // R07
			rx_chain_en_r    <= sub_nxt == SUB_RX; // R07
			active_idle_r    <= sub_nxt == SUB_IDLE; // R08
		end
	end

	// ----------------------------------------------------------------
	// Wake timer on the RC tick, restarted by each beacon
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			wake_cnt_r <= `PSS_WAKE_RST;
		end else if (state_r == ST_SHUT) begin
			wake_cnt_r <= `PSS_WAKE_RST; // R01
		end else if (dtim_beacon) begin
			wake_cnt_r <= `PSS_WAKE_RST; // R22
		end else if (rc_tick && (wake_cnt_r != {`PSS_WAKE_W{1'b1}})) begin
			wake_cnt_r <= wake_cnt_r + {{(`PSS_WAKE_W-1){1'b0}}, 1'b1}; // R22
		end
	end

	// ----------------------------------------------------------------
	// RC period measured in crystal-referenced cycles
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			cal_cnt_r      <= `PSS_CAL_RST;
			rc_period_r    <= `PSS_CAL_RST;
			rc_cal_valid_r <= 1'b0;
		end else if (state_r == ST_SHUT) begin
			cal_cnt_r      <= `PSS_CAL_RST; // R01
			rc_period_r    <= `PSS_CAL_RST;
			rc_cal_valid_r <= 1'b0;
		end else if (state_r != ST_ACT) begin
			cal_cnt_r <= `PSS_CAL_RST;
		end else if (rc_tick) begin
			// The tick cycle itself belongs to the next period
			cal_cnt_r      <= {{(`PSS_CAL_W-1){1'b0}}, 1'b1}; // R21
			rc_period_r    <= cal_cnt_r; // R21
			rc_cal_valid_r <= rc_cal_valid_r | (cal_cnt_r != `PSS_CAL_RST);
		end else if (cal_cnt_r != {`PSS_CAL_W{1'b1}}) begin
			cal_cnt_r <= cal_cnt_r + {{(`PSS_CAL_W-1){1'b0}}, 1'b1}; // R21
		end
	end

	// ----------------------------------------------------------------
	// Crystal trim, clamped to the allowed range
	// ----------------------------------------------------------------
	assign trim_hi = $signed(otp_trim) > $signed(`PSS_TRIM_MAX);
	assign trim_lo = $signed(otp_trim) < $signed(`PSS_TRIM_MIN);

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			xo_trim_r <= `PSS_TRIM_RST;
		end else if (state_r == ST_SHUT) begin
			xo_trim_r <= `PSS_TRIM_RST; // R01
		end else if (state_r == ST_BBINIT && from_shut_r && otp_trim_valid) begin
			if (trim_hi)
				xo_trim_r <= `PSS_TRIM_MAX; // R20
			else if (trim_lo)
				xo_trim_r <= `PSS_TRIM_MIN; // R20
			else
				xo_trim_r <= otp_trim; // R20
		end
	end
endmodule

// >>> verification/pss_host_model.sv
`timescale 1ns/1ps
module pss_host_model (
	input  wire sys_clk,
	input  wire want_power,
	input  wire want_access,
	input  wire want_boot,
	output reg  supply_enable_input,
	output reg  host_access,
	output reg  boot_done
);
	// Host moves its pins just after the clock edge
	always @(posedge sys_clk) begin
		supply_enable_input <= want_power;
		host_access <= want_access;
		boot_done <= want_boot;
	end
endmodule

// >>> verification/pss_sequencer_props.sv
`timescale 1ns/1ps
`include "pss_regs.vh"
module pss_sequencer_props (
	input wire                   sys_clk,
	input wire                   sys_rst,
	input wire                   supply_enable_input,
	input wire                   host_access,
	input wire                   regulator_pwm_r,
	input wire                   pulse_frequency_regulation_r,
	input wire                   logic_pwr_r,
	input wire                   retention_ram_pwr_r,
	input wire                   host_if_pwr_r,
	input wire                   xo_en_r,
	input wire                   pll_en_r,
	input wire                   rf_cal_req_r,
	input wire                   rf_cal_all_bands_r,
	input wire                   state_shutdown_r,
	input wire                   state_sleep_r,
	input wire                   state_active_r,
	input wire                   tx_chain_en_r,
	input wire                   rx_chain_en_r,
	input wire                   active_idle_r,
	input wire                   booted_r,
	input wire [`PSS_TRIM_W-1:0] xo_trim_r
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------------------------------
	// Wake steps, power states, sub-states, trim range and calibration origin
	// ----------------------------------------------------------------
	sequence s_pmu_step;
		regulator_pwm_r && !logic_pwr_r;
	endsequence
	sequence s_pwr_xo;
		logic_pwr_r && !xo_en_r ##1 xo_en_r && logic_pwr_r;
	endsequence
	a_wake_order: assert property (
		disable iff (sys_rst || !supply_enable_input)
		$rose(regulator_pwm_r) |-> s_pmu_step ##1 s_pwr_xo) else $error("wake steps out of order");
	a_pll_after_xo: assert property (
		$rose(pll_en_r) |-> xo_en_r && $past(xo_en_r)) else $error("pll before crystal");
	a_shut_hold: assert property (
		state_shutdown_r && !supply_enable_input |=> state_shutdown_r) else $error("left shutdown");
	a_enable_off: assert property (
		!supply_enable_input |=> state_shutdown_r && !regulator_pwm_r) else $error("no shutdown");
	a_shut_power: assert property (
		state_shutdown_r |-> !(retention_ram_pwr_r || host_if_pwr_r || logic_pwr_r
			|| regulator_pwm_r || pulse_frequency_regulation_r)) else $error("power in shutdown");
	a_sleep_power: assert property (
		state_sleep_r |-> pulse_frequency_regulation_r && !regulator_pwm_r && !xo_en_r
			&& !pll_en_r && !logic_pwr_r && retention_ram_pwr_r && host_if_pwr_r)
		else $error("sleep power wrong");
	a_active_sub: assert property (
		state_active_r |-> $onehot({tx_chain_en_r, rx_chain_en_r, active_idle_r})
			&& regulator_pwm_r && pll_en_r) else $error("active sub-state wrong");
	a_access_wake: assert property (
		state_sleep_r && host_access && supply_enable_input |=> regulator_pwm_r && !state_sleep_r)
		else $error("no wake on access");
	a_sleep_entry: assert property (
		$rose(state_sleep_r) |-> $past(booted_r) && $past(active_idle_r) && !$past(host_access))
		else $error("bad sleep entry");
	a_trim_range: assert property (
		$signed(xo_trim_r) <= 8'sh14 && $signed(xo_trim_r) >= 8'shEC) else $error("trim range");
	a_cal_origin: assert property (
		rf_cal_all_bands_r |-> rf_cal_req_r) else $error("full cal outside cal step");
endmodule
bind pss_sequencer pss_sequencer_props pss_sequencer_props_inst (.*);

// >>> verification/pss_sequencer_bench.sv
`timescale 1ns/1ps
`include "pss_regs.vh"
module pss_sequencer_bench;
	localparam XO_C = 8;
	localparam TICK_P = 20;
	reg  sys_clk, sys_rst, want_power, want_access, want_boot;
	wire supply_enable_input, host_access, boot_done;
	reg  host_activity_pending, associated, ps_sleep_allowed, tx_req, rx_req, rx_abort;
	reg  xo_settled, pll_settled, dtim_beacon, otp_trim_valid;
	reg  cores_booted = 1'b0, bb_init_done = 1'b0, rf_cal_done = 1'b0, rc_tick = 1'b0;
	reg  [`PSS_WAKE_W-1:0] wake_interval;
	reg  [`PSS_TRIM_W-1:0] otp_trim;
	wire regulator_pwm_r, pulse_frequency_regulation_r, logic_pwr_r, scratch_ram_pwr_r;
	wire analog_pwr_r, retention_ram_pwr_r, host_if_pwr_r, rc_osc_en_r, xo_en_r, pll_en_r;
	wire core_run_r, bb_init_req_r, factory_info_block_copy_r, rf_cal_req_r;
	wire rf_cal_all_bands_r, state_shutdown_r, state_sleep_r, state_active_r;
	wire tx_chain_en_r, rx_chain_en_r, active_idle_r, booted_r, rc_cal_valid_r;
	wire [`PSS_TRIM_W-1:0] xo_trim_r;
	wire [`PSS_CAL_W-1:0]  rc_period_r;
	wire [5:0] ev = {regulator_pwm_r, rf_cal_req_r, bb_init_req_r, pll_en_r,
		state_sleep_r, state_active_r};
	integer n_mismatch, num_checks, i, n, r;
	integer cyc = 0, tk = 0;

	pss_sequencer #(.XO_SETTLE_CYC(XO_C), .PLL_SETTLE_CYC(4)) pss_sequencer_inst (.*);
	pss_host_model pss_host_model_inst (.*);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// ----------------------------------------------------------------
	// Far-side step responders, RC tick and timeout
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		tk <= (tk == TICK_P - 1) ? 0 : tk + 1;
		rc_tick <= (tk == TICK_P - 1);
		cores_booted <= core_run_r;
		bb_init_done <= bb_init_req_r;
		rf_cal_done <= rf_cal_req_r;
		if (cyc == 6000) begin
			n_mismatch = n_mismatch + 1;
			complete_run;
		end
	end
	// ----------------------------------------------------------------
	// Reference model and helpers
	// ----------------------------------------------------------------
	function [7:0] clamp(input [7:0] v);
		clamp = ($signed(v) > 20) ? 8'h14 : (($signed(v) < -20) ? 8'hEC : v);
	endfunction
	function [2:0] exp_sub(input [2:0] q);
		exp_sub = q[2] ? 3'h4 : ((q[1] && !q[0]) ? 3'h2 : 3'h1);
	endfunction
	task check(input [31:0] seen, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task wait_on(input integer k, output integer m);
		begin
			m = 0;
			while (ev[k] !== 1'b1 && m < 2000) begin
				@(posedge sys_clk);
				#1;
				m = m + 1;
			end
		end
	endtask
	task wake_seq(input [31:0] from_shut, input [31:0] exp_d);
		integer m;
		begin
			wait_on(5, m);
			wait_on(2, m);
			check(m, exp_d);
			wait_on(3, m);
			check(factory_info_block_copy_r, from_shut);
			wait_on(4, m);
			check(rf_cal_all_bands_r, from_shut);
			wait_on(0, m);
			check(active_idle_r, 1);
			check({scratch_ram_pwr_r, analog_pwr_r, core_run_r}, 7);
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", num_checks, n_mismatch);
			if (n_mismatch == 0 && num_checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		n_mismatch = 0; num_checks = 0; sys_rst = 1'b1;
		{want_power, want_access, want_boot, host_activity_pending, associated} = 5'h00;
		{ps_sleep_allowed, tx_req, rx_req, rx_abort, xo_settled, pll_settled} = 6'h00;
		dtim_beacon = 1'b0;
		otp_trim_valid = 1'b0; wake_interval = 16'h0000; otp_trim = 8'h00;
		r = $urandom(32'h9DEBFEE8);
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (20) begin
			@(posedge sys_clk);
			r = $urandom;
			{want_access, host_activity_pending, tx_req, rx_req, xo_settled, dtim_beacon} <= r[5:0];
		end
		#1 check(state_shutdown_r, 1);
		check(host_if_pwr_r, 0);
		check({scratch_ram_pwr_r, analog_pwr_r, rc_osc_en_r}, 0);
		@(posedge sys_clk);
		{want_access, host_activity_pending, tx_req, rx_req, xo_settled, dtim_beacon} <= 6'h00;
		r = $urandom;
		otp_trim <= r[7:0];
		otp_trim_valid <= 1'b1;
		want_power <= 1'b1;
		wake_seq(1, 2 + XO_C + 1);
		check(xo_trim_r, clamp(otp_trim));
		repeat (45) @(posedge sys_clk);
		#1 check(state_active_r, 1);
		check({rc_cal_valid_r, rc_period_r}, {1'b1, 16'h0014});
		@(posedge sys_clk) host_activity_pending <= 1'b1;
		want_boot <= 1'b1;
		@(posedge sys_clk) want_boot <= 1'b0;
		repeat (30) @(posedge sys_clk);
		#1 check(state_active_r, 1);
		@(posedge sys_clk) host_activity_pending <= 1'b0;
		wait_on(1, n);
		check(state_sleep_r, 1);
		check({scratch_ram_pwr_r, analog_pwr_r, rc_osc_en_r}, 1);
		@(posedge sys_clk) dtim_beacon <= 1'b1;
		@(posedge sys_clk) dtim_beacon <= 1'b0;
		wake_interval <= 16'h0003;
		n = 0;
		#1;
		// Count every tick the design samples from the edge after the beacon on
		for (i = 0; i < 500 && state_sleep_r === 1'b1; i = i + 1) begin
			if (rc_tick === 1'b1)
				n = n + 1;
			@(posedge sys_clk);
			#1;
		end
		check(n, 3);
		@(posedge sys_clk) wake_interval <= 16'h0000;
		associated <= 1'b1;
		// The wake began one edge before this call
		wake_seq(0, 1 + XO_C + 1);
		for (i = 0; i < 8; i = i + 1) begin
			@(posedge sys_clk) {tx_req, rx_req, rx_abort} <= i[2:0];
			repeat (2) @(posedge sys_clk);
			#1 check({tx_chain_en_r, rx_chain_en_r, active_idle_r}, exp_sub(i[2:0]));
		end
		check(state_active_r, 1);
		@(posedge sys_clk) {tx_req, rx_req, rx_abort} <= 3'h0;
		ps_sleep_allowed <= 1'b1;
		wait_on(1, n);
		check(state_sleep_r, 1);
		@(posedge sys_clk) want_access <= 1'b1;
		xo_settled <= 1'b1;
		pll_settled <= 1'b1;
		@(posedge sys_clk) want_access <= 1'b0;
		ps_sleep_allowed <= 1'b0;
		wake_seq(0, 3);
		@(posedge sys_clk) want_power <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1 check({state_shutdown_r, xo_trim_r}, 9'h100);
		complete_run;
	end
endmodule
